// [src/cbs_ctrl_core.sv]
// Branch, system-control and block-copy execution slice with a
// Wishbone register slave and a simple memory master port.
// Holds each memory request steady until memory answers with ack.
//
// Overview of operation
// - Conditional branch jumps only when condition true
// - Sixteen conditions over carry, zero, overflow, negative
// - Condition comes from the condition field
// - Subroutine return resumes at saved address
// - Exception return restores flags and program flow
// - Sleep enters power-down until woken
// - Load flags from operand; memory read is word
// - Store flags; memory write is word sized
// - Flags AND, OR, XOR with immediate byte
// - No-operation only adds two to PC
// - Byte-count copy loops; zero count does nothing
// - Word-count copy uses sixteen-bit count
// - After copy, five write-back cycles precede the next instruction
// - Instructions are built of two-byte words
// - Operation field is top four bits
// - Register fields: address 3 bits, data 3/4
// - Extension 8/16/32; 24-bit has zero top byte
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "cbs_cfg.svh"
module cbs_ctrl_core
  import cbs_pkg::*;
(
  input  wire logic        clk_i,       // System clock, 25 MHz
  input  wire logic        rst_i,       // Sync reset, active high
  input  wire logic        wb_cyc_i,    // Wishbone cycle
  input  wire logic        wb_stb_i,    // Wishbone strobe
  input  wire logic        wb_we_i,     // Wishbone write
  input  wire logic [7:0]  wb_adr_i,    // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,    // Wishbone byte enables
  input  wire logic [31:0] wb_dat_i,    // Wishbone write data
  output logic      [31:0] wb_dat_o,    // Wishbone read data
  output logic             wb_ack_o,    // Wishbone acknowledge
  output logic             mem_req_o,   // Memory request
  output logic             mem_we_o,    // Memory write
  output logic      [1:0]  mem_size_o,  // Byte, word or long
  output logic      [23:0] mem_addr_o,  // Memory address
  output logic      [31:0] mem_wdata_o, // Memory write data
  input  wire logic [31:0] mem_rdata_i, // Memory read data
  input  wire logic        mem_ack_i,   // Memory answer
  input  wire logic        wake_i,      // Leave power-down
  output logic             sleep_o      // In power-down
);
  cbs_state_t  state, next_state;
  cbs_size_t   msize, next_msize;
  logic [15:0] insn, next_insn;
  logic [31:0] ext, next_ext;
  logic [23:0] pc, next_pc;
  logic [7:0]  condition_code_reg, next_ccr;
  logic [31:0] cnt, next_cnt;
  logic [31:0] src, next_src;
  logic [31:0] dst, next_dst;
  logic [31:0] sp, next_sp;
  logic [31:0] fld, next_fld;
  logic [2:0]  step, next_step;
  logic        mph, next_mph;
  logic        fwr, next_fwr;
  logic        taken, next_taken;
  logic        illegal, next_illegal;
  logic [23:0] maddr, next_maddr;
  logic [31:0] mwdata, next_mwdata;
  logic        mwe, next_mwe;
  logic        wb_ph, next_wb_ph;
  logic        ack, next_ack;
  logic [31:0] dat, next_dat;

  cbs_op_t     op;
  logic [3:0]  sub;
  logic [31:0] ea;
  logic [23:0] ilen;
  logic [23:0] disp;
  logic [15:0] left;
  logic [2:0]  fld_sel;
  logic [7:0]  fbyte;
  logic        cond_true;
  logic        idle;
  logic        commit;
  logic [31:0] wmask;
  logic        rf_we;
  logic [2:0]  rf_waddr;
  logic [31:0] rf_wdata;
  logic [2:0]  rf_raddr;
  logic [31:0] rf_rdata;

  assign op   = cbs_op_t'(insn[`CBS_OP_HI:`CBS_OP_LO]);
  assign sub  = insn[`CBS_SUB_HI:`CBS_SUB_LO];
  assign disp = {{16{insn[`CBS_IMM_HI]}}, insn[`CBS_IMM_HI:`CBS_IMM_LO]};
  assign idle = (state == ST_IDLE);
  assign commit = ack & wb_cyc_i & wb_stb_i & wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Count width picked by the second operation field
  assign left = sub[0] ? cnt[15:0] : {8'h00, cnt[7:0]};
  assign fld_sel = (sub == `CBS_SUB_MEM)
                 ? insn[`CBS_AREG_HI:`CBS_AREG_LO]
                 : insn[`CBS_DREG_HI:`CBS_DREG_LO];
  assign fbyte = insn[`CBS_DREG_HB] ? fld[15:8] : fld[7:0];

  // Extension size code; a 24-bit value rides in 32 with top byte zero
  always_comb
  begin
    unique case (insn[`CBS_ESZ_HI:`CBS_ESZ_LO])
      2'h0: ea = {24'h000000, insn[`CBS_IMM_HI:`CBS_IMM_LO]};
      2'h1: ea = {16'h0000, ext[15:0]};
      2'h2: ea = {8'h00, ext[23:0]};
      2'h3: ea = ext;
    endcase
    // Whole words only: insn word plus 0, 1 or 2 extension words
    ilen = `CBS_WORD_LEN;
    if ((op == OP_JMP || op == OP_JSR) &&
        insn[`CBS_ESZ_HI:`CBS_ESZ_LO] != 2'h0)
      ilen = (insn[`CBS_ESZ_HI:`CBS_ESZ_LO] == 2'h1)
           ? `CBS_WORD_LEN + `CBS_WORD_LEN
           : `CBS_WORD_LEN + `CBS_LONG_LEN;
  end

  cbs_cond_eval u_cond (
    .cond_i  (sub),
    .ccr_i   (condition_code_reg),
    .taken_o (cond_true)
  );

  // Shared ports: Wishbone owns the file only while the core is idle
  always_comb
  begin
    rf_raddr = idle ? wb_adr_i[4:2]
             : (step < `CBS_STEP_FLD) ? `CBS_REG_CNT + step : fld_sel;
    rf_we    = idle ? (commit && wb_adr_i[7:5] == `CBS_ADR_GPR)
             : (state == ST_WB && (step < `CBS_STEP_FLD || fwr));
    rf_waddr = idle ? wb_adr_i[4:2]
             : (step < `CBS_STEP_FLD) ? `CBS_REG_CNT + step : fld_sel;
    unique case (step)
      3'h0:    rf_wdata = cnt;
      3'h1:    rf_wdata = src;
      3'h2:    rf_wdata = dst;
      3'h3:    rf_wdata = sp;
      default: rf_wdata = fld;
    endcase
    if (idle)
      rf_wdata = (rf_rdata & ~wmask) | (wb_dat_i & wmask);
  end

  cbs_regfile u_rf (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (rf_we),
    .waddr_i (rf_waddr),
    .wdata_i (rf_wdata),
    .raddr_i (rf_raddr),
    .rdata_o (rf_rdata)
  );

  always_comb
  begin
    next_state = state;   next_insn = insn;     next_ext = ext;
    next_pc = pc;         next_ccr = condition_code_reg;       next_cnt = cnt;
    next_src = src;       next_dst = dst;       next_sp = sp;
    next_fld = fld;       next_step = step;     next_mph = mph;
    next_fwr = fwr;       next_taken = taken;
    next_illegal = illegal;
    next_maddr = maddr;   next_mwdata = mwdata; next_mwe = mwe;
    next_msize = msize;
    unique case (state)
      ST_IDLE:
      begin
        if (commit)
        begin
          if (wb_adr_i == `CBS_ADR_INSN)
            next_insn = (insn & ~wmask[15:0])
                      | (wb_dat_i[15:0] & wmask[15:0]);
          if (wb_adr_i == `CBS_ADR_EXT)
            next_ext = (ext & ~wmask) | (wb_dat_i & wmask);
          if (wb_adr_i == `CBS_ADR_PC)
            next_pc = (pc & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
          if (wb_adr_i == `CBS_ADR_CCR && wb_sel_i[0])
            next_ccr = wb_dat_i[7:0];
          if (wb_adr_i == `CBS_ADR_GO && wb_sel_i[0] && wb_dat_i[0])
          begin
            next_state = ST_LOADR;
            next_step = 3'h0;
            next_taken = 1'b0;
            next_illegal = 1'b0;
            next_fwr = 1'b0;
          end
        end
      end
      ST_LOADR:
      begin
        // Read data lags the index by one cycle
        unique case (step)
          3'h1:    next_cnt = rf_rdata;
          3'h2:    next_src = rf_rdata;
          3'h3:    next_dst = rf_rdata;
          3'h4:    next_sp = rf_rdata;
          3'h5:    next_fld = rf_rdata;
          default: next_cnt = cnt;
        endcase
        next_step = step + 3'h1;
        if (step == `CBS_STEP_END)
          next_state = ST_EXEC;
      end
      ST_EXEC:
      begin
        next_pc = pc + ilen;
        next_state = ST_IDLE;
        next_step = 3'h0;
        next_mph = 1'b0;
        unique case (op)
          OP_NOP: next_pc = pc + `CBS_WORD_LEN;
          OP_BCC:
          begin
            next_taken = cond_true;
            if (cond_true)
              next_pc = pc + `CBS_WORD_LEN + disp;
          end
          OP_JMP: next_pc = ea[23:0];
          OP_BSR, OP_JSR:
          begin
            // Return address is the next instruction's
            next_sp = sp - 32'(`CBS_LONG_LEN);
            next_maddr = 24'(sp - 32'(`CBS_LONG_LEN));
            next_mwdata = {8'h00, pc + ilen};
            next_mwe = 1'b1;
            next_msize = SZ_LONG;
            next_pc = (op == OP_BSR) ? pc + `CBS_WORD_LEN + disp
                                     : ea[23:0];
            next_state = ST_MEM;
          end
          OP_RTS, OP_RTE:
          begin
            next_maddr = sp[23:0];
            next_mwe = 1'b0;
            next_msize = (op == OP_RTE) ? SZ_WORD : SZ_LONG;
            next_state = ST_MEM;
          end
          OP_SLP: next_state = ST_SLEEP;
          OP_LDC, OP_STC:
          begin
            if (sub == `CBS_SUB_IMM && op == OP_LDC)
              next_ccr = insn[`CBS_IMM_HI:`CBS_IMM_LO];
            else if (sub == `CBS_SUB_REG && op == OP_LDC)
              next_ccr = fbyte;
            else if (sub == `CBS_SUB_REG)
            begin
              next_fld = insn[`CBS_DREG_HB] ? {fld[31:16], condition_code_reg, fld[7:0]}
                                            : {fld[31:8], condition_code_reg};
              next_fwr = 1'b1;
              next_state = ST_WB;
            end
            else if (sub == `CBS_SUB_MEM)
            begin
              // Flags sit in the high byte of the word
              next_maddr = fld[23:0];
              next_mwe = (op == OP_STC);
              next_mwdata = {16'h0000, condition_code_reg, 8'h00};
              next_msize = SZ_WORD;
              next_state = ST_MEM;
            end
            else
              next_illegal = 1'b1;
          end
          OP_AND: next_ccr = condition_code_reg & insn[`CBS_IMM_HI:`CBS_IMM_LO];
          OP_OR:  next_ccr = condition_code_reg | insn[`CBS_IMM_HI:`CBS_IMM_LO];
          OP_XOR: next_ccr = condition_code_reg ^ insn[`CBS_IMM_HI:`CBS_IMM_LO];
          OP_CPY:
          begin
            if (sub[3:1] != 3'h0)
              next_illegal = 1'b1;
            else if (left != 16'h0000)
            begin
              next_maddr = src[23:0];
              next_mwe = 1'b0;
              next_msize = SZ_BYTE;
              next_state = ST_CP_RD;
            end
          end
          default: next_illegal = 1'b1;
        endcase
      end
      ST_MEM:
      begin
        if (mem_ack_i)
        begin
          next_state = ST_WB;
          if (op == OP_RTS)
          begin
            next_pc = mem_rdata_i[23:0];
            next_sp = sp + 32'(`CBS_LONG_LEN);
          end
          else if (op == OP_RTE && !mph)
          begin
            // Flags word first, then the saved program counter
            next_ccr = mem_rdata_i[15:8];
            next_sp = sp + 32'(`CBS_WORD_LEN);
            next_maddr = 24'(sp + 32'(`CBS_WORD_LEN));
            next_msize = SZ_LONG;
            next_mph = 1'b1;
            next_state = ST_MEM;
          end
          else if (op == OP_RTE)
          begin
            next_pc = mem_rdata_i[23:0];
            next_sp = sp + 32'(`CBS_LONG_LEN);
          end
          else if (op == OP_LDC)
            next_ccr = mem_rdata_i[15:8];
        end
      end
      ST_CP_RD:
      begin
        if (mem_ack_i)
        begin
          next_maddr = dst[23:0];
          next_mwdata = {24'h000000, mem_rdata_i[7:0]};
          next_mwe = 1'b1;
          next_state = ST_CP_WR;
        end
      end
      ST_CP_WR:
      begin
        if (mem_ack_i)
        begin
          // Post-increment both pointers, count down
          next_src = src + 32'h00000001;
          next_dst = dst + 32'h00000001;
          if (sub[0])
            next_cnt = {cnt[31:16], left - 16'h0001};
          else
            next_cnt = {cnt[31:8], cnt[7:0] - 8'h01};
          next_maddr = 24'(src + 32'h00000001);
          next_mwe = 1'b0;
          next_state = (left == 16'h0001) ? ST_WB : ST_CP_RD;
        end
      end
      ST_WB:
      begin
        next_step = step + 3'h1;
        if (step == `CBS_STEP_FLD)
          next_state = ST_IDLE;
      end
      ST_SLEEP:
      begin
        if (wake_i)
          next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;     insn <= `CBS_INSN_RST;  ext <= 32'h00000000;
      pc <= `CBS_PC_RST;    condition_code_reg <= `CBS_CCR_RST;    cnt <= 32'h00000000;
      src <= 32'h00000000;  dst <= 32'h00000000;    sp <= 32'h00000000;
      fld <= 32'h00000000;  step <= 3'h0;           mph <= 1'b0;
      fwr <= 1'b0;          taken <= 1'b0;
      illegal <= 1'b0;      maddr <= 24'h000000;    mwdata <= 32'h00000000;
      mwe <= 1'b0;          msize <= SZ_BYTE;
    end
    else
    begin
      state <= next_state;  insn <= next_insn;      ext <= next_ext;
      pc <= next_pc;        condition_code_reg <= next_ccr;        cnt <= next_cnt;
      src <= next_src;      dst <= next_dst;        sp <= next_sp;
      fld <= next_fld;      step <= next_step;      mph <= next_mph;
      fwr <= next_fwr;      taken <= next_taken;
      illegal <= next_illegal;
      maddr <= next_maddr;  mwdata <= next_mwdata;  mwe <= next_mwe;
      msize <= next_msize;
    end
  end

  // Two-cycle answer gives the register file its read latency
  always_comb
  begin
    next_wb_ph = 1'b0;
    next_ack = 1'b0;
    next_dat = dat;
    if (wb_cyc_i && wb_stb_i && !wb_ph && !ack)
      next_wb_ph = 1'b1;
    if (wb_ph)
    begin
      next_ack = 1'b1;
      unique case (wb_adr_i)
        `CBS_ADR_INSN: next_dat = {16'h0000, insn};
        `CBS_ADR_EXT:  next_dat = ext;
        `CBS_ADR_STAT: next_dat = {28'h0000000, sleep_o, illegal,
                                   taken, !idle};
        `CBS_ADR_PC:   next_dat = {8'h00, pc};
        `CBS_ADR_CCR:  next_dat = {24'h000000, condition_code_reg};
        default:
          next_dat = (wb_adr_i[7:5] == `CBS_ADR_GPR && idle)
                   ? rf_rdata : 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ph <= 1'b0;
      ack <= 1'b0;
      dat <= 32'h00000000;
    end
    else
    begin
      wb_ph <= next_wb_ph;
      ack <= next_ack;
      dat <= next_dat;
    end
  end

  assign wb_ack_o    = ack;
  assign wb_dat_o    = dat;
  assign mem_req_o   = (state == ST_MEM) || (state == ST_CP_RD) ||
                       (state == ST_CP_WR);
  assign mem_we_o    = mwe;
  assign mem_size_o  = msize;
  assign mem_addr_o  = maddr;
  assign mem_wdata_o = mwdata;
  assign sleep_o     = (state == ST_SLEEP);
endmodule
`default_nettype wire

// [src/cbs_cfg.svh]
// Offsets, field positions and reset values of the branch/sysctl slice.
// Included by the design files; definitions only.
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH
`define CBS_ADR_INSN  8'h00
`define CBS_ADR_EXT   8'h04
`define CBS_ADR_GO    8'h08
`define CBS_ADR_STAT  8'h0C
`define CBS_ADR_PC    8'h10
`define CBS_ADR_CCR   8'h14
`define CBS_ADR_GPR   3'h1
`define CBS_OP_HI     15
`define CBS_OP_LO     12
`define CBS_SUB_HI    11
`define CBS_SUB_LO    8
`define CBS_ESZ_HI    9
`define CBS_ESZ_LO    8
`define CBS_AREG_HI   6
`define CBS_AREG_LO   4
`define CBS_DREG_HI   2
`define CBS_DREG_LO   0
`define CBS_DREG_HB   3
`define CBS_IMM_HI    7
`define CBS_IMM_LO    0
`define CBS_SUB_IMM   4'h0
`define CBS_SUB_REG   4'h1
`define CBS_SUB_MEM   4'h2
`define CBS_CCR_C     0
`define CBS_CCR_V     1
`define CBS_CCR_Z     2
`define CBS_CCR_N     3
`define CBS_ST_BUSY   0
`define CBS_ST_TAKEN  1
`define CBS_ST_ILL    2
`define CBS_ST_SLEEP  3
`define CBS_PC_RST    24'h000000
`define CBS_CCR_RST   8'h00
`define CBS_INSN_RST  16'h0000
`define CBS_WORD_LEN  24'h000002
`define CBS_LONG_LEN  24'h000004
`define CBS_REG_CNT   3'h4
`define CBS_STEP_FLD  3'h4
`define CBS_STEP_END  3'h5
`endif

// [src/cbs_pkg.sv]
// Types shared by the branch/sysctl slice: states, opcodes, conditions.
// Used with cbs_cfg.svh.
package cbs_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_LOADR = 8'h02,
    ST_EXEC  = 8'h04,
    ST_MEM   = 8'h08,
    ST_CP_RD = 8'h10,
    ST_CP_WR = 8'h20,
    ST_WB    = 8'h40,
    ST_SLEEP = 8'h80
  } cbs_state_t;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_BCC = 4'h1, OP_JMP = 4'h2, OP_BSR = 4'h3,
    OP_JSR = 4'h4, OP_RTS = 4'h5, OP_RTE = 4'h6, OP_SLP = 4'h7,
    OP_LDC = 4'h8, OP_STC = 4'h9, OP_AND = 4'hA, OP_OR  = 4'hB,
    OP_XOR = 4'hC, OP_CPY = 4'hD, OP_RSE = 4'hE, OP_RSF = 4'hF
  } cbs_op_t;
  typedef enum logic [3:0] {
    CC_ALW = 4'h0, CC_NEV = 4'h1, CC_HI = 4'h2, CC_LS = 4'h3,
    CC_CC  = 4'h4, CC_CS  = 4'h5, CC_NE = 4'h6, CC_EQ = 4'h7,
    CC_VC  = 4'h8, CC_VS  = 4'h9, CC_PL = 4'hA, CC_MI = 4'hB,
    CC_GE  = 4'hC, CC_LT  = 4'hD, CC_GT = 4'hE, CC_LE = 4'hF
  } cbs_cond_t;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } cbs_size_t;
endpackage

// [src/cbs_cond_eval.sv]
// Branch condition evaluator: condition field against the flags.
// Purely combinational; fed from the core's condition code register.
`timescale 1ns/100ps
`default_nettype none
`include "cbs_cfg.svh"
module cbs_cond_eval
  import cbs_pkg::*;
(
  input  wire logic [3:0] cond_i,   // Condition field
  input  wire logic [7:0] ccr_i,    // Condition code register
  output logic            taken_o   // Condition true
);
  logic c;
  logic v;
  logic z;
  logic n;
  always_comb
  begin
    c = ccr_i[`CBS_CCR_C];
    v = ccr_i[`CBS_CCR_V];
    z = ccr_i[`CBS_CCR_Z];
    n = ccr_i[`CBS_CCR_N];
    unique case (cbs_cond_t'(cond_i))
      CC_ALW: taken_o = 1'b1;
      CC_NEV: taken_o = 1'b0;
      CC_HI:  taken_o = ~(c | z);
      CC_LS:  taken_o = c | z;
      CC_CC:  taken_o = ~c;
      CC_CS:  taken_o = c;
      CC_NE:  taken_o = ~z;
      CC_EQ:  taken_o = z;
      CC_VC:  taken_o = ~v;
      CC_VS:  taken_o = v;
      CC_PL:  taken_o = ~n;
      CC_MI:  taken_o = n;
      CC_GE:  taken_o = ~(n ^ v);
      CC_LT:  taken_o = n ^ v;
      CC_GT:  taken_o = ~(z | (n ^ v));
      CC_LE:  taken_o = z | (n ^ v);
    endcase
  end
endmodule
`default_nettype wire

// [src/cbs_regfile.sv]
// Eight 32-bit general registers, one write port, registered read port.
// Read data appears the cycle after the address.
`timescale 1ns/100ps
`default_nettype none
module cbs_regfile
(
  input  wire logic        clk_i,    // System clock
  input  wire logic        rst_i,    // Sync reset, active high
  input  wire logic        we_i,     // Write strobe
  input  wire logic [2:0]  waddr_i,  // Write index
  input  wire logic [31:0] wdata_i,  // Write data
  input  wire logic [2:0]  raddr_i,  // Read index
  output logic      [31:0] rdata_o   // Read data, registered
);
  logic [31:0] gpr [8];
  for (genvar i = 0; i < 8; i++)
  begin : g_ent
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        gpr[i] <= 32'h00000000;
      else if (we_i && waddr_i == 3'(i))
        gpr[i] <= wdata_i;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 32'h00000000;
    else
      rdata_o <= gpr[raddr_i];
  end
endmodule
`default_nettype wire

// [tb/cbs_ctrl_assertions.sv]
// Port checks for the branch/sysctl slice.
// Bound into cbs_ctrl_core; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cbs_ctrl_assertions
(
  input wire logic        clk_i,       // Clock
  input wire logic        rst_i,       // Reset
  input wire logic        wb_stb_i,    // Strobe
  input wire logic        wb_ack_o,    // Ack
  input wire logic        mem_req_o,   // Mem request
  input wire logic        mem_we_o,    // Mem write
  input wire logic [1:0]  mem_size_o,  // Mem size
  input wire logic [23:0] mem_addr_o,  // Mem address
  input wire logic [31:0] mem_wdata_o, // Mem write data
  input wire logic [31:0] mem_rdata_i, // Mem read data
  input wire logic        mem_ack_i,   // Mem answer
  input wire logic        wake_i,      // Wake
  input wire logic        sleep_o      // Asleep
);
  logic [7:0] cap;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Last byte read, so the write may trail it by one to three cycles
  always_ff @(posedge clk_i)
    if (mem_req_o && mem_ack_i && !mem_we_o)
      cap <= mem_rdata_i[7:0];
  AST_ACK_LAT: assert property ($rose(wb_stb_i) |->
    !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack latency");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> wb_stb_i && $past(wb_stb_i, 2))
    else $error("ack without request");
  AST_MEM_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
    $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_size_o))
    else $error("memory request changed before answer");
  AST_COPY_DATA: assert property (
    mem_req_o && mem_ack_i && !mem_we_o && mem_size_o == 2'h0 |->
    ##[1:3] (mem_req_o && mem_we_o && mem_size_o == 2'h0 &&
    mem_wdata_o[7:0] == cap)) else $error("copied byte differs");
  AST_SLEEP_WAKE: assert property (
    sleep_o && wake_i |-> ##[1:4] !sleep_o) else $error("wake ignored");
  AST_SLEEP_QUIET: assert property (sleep_o |-> !mem_req_o)
    else $error("memory access while asleep");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !mem_req_o && !sleep_o)
    else $error("outputs active after reset");
  cover property (mem_req_o && mem_we_o && mem_size_o == 2'h0 && mem_ack_i);
  cover property (mem_req_o && mem_size_o == 2'h1 && mem_ack_i);
  cover property (sleep_o && wake_i);
endmodule
bind cbs_ctrl_core cbs_ctrl_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_size_o(mem_size_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
  .mem_ack_i(mem_ack_i), .wake_i(wake_i), .sleep_o(sleep_o));
`default_nettype wire

// [tb/cbs_mem_model.sv]
// Memory behind the slice's master port, big-endian, 256 bytes.
// Wait states from lat_i; bus data toggles except on a read answer.
`timescale 1ns/100ps
`default_nettype none
module cbs_mem_model
(
  input  wire logic        clk_i,   // Clock
  input  wire logic        rst_i,   // Reset
  input  wire logic        req_i,   // Request
  input  wire logic        we_i,    // Write
  input  wire logic [1:0]  size_i,  // Size code
  input  wire logic [23:0] addr_i,  // Address
  input  wire logic [31:0] wdata_i, // Write data
  input  wire logic [3:0]  lat_i,   // Wait states
  output logic      [31:0] rdata_o, // Read data
  output logic             ack_o    // Answer
);
  logic [7:0] mem [256];
  logic [3:0] cnt;
  logic [7:0] a;
  assign a = addr_i[7:0];
  always @(posedge clk_i)
  begin
    rdata_o <= rst_i ? 32'h5A5A_A5A5 : ~rdata_o;
    ack_o <= 1'b0;
    if (rst_i || !req_i || ack_o)
      cnt <= 4'h0;
    else if (cnt != lat_i)
      cnt <= cnt + 4'h1;
    else
    begin
      ack_o <= 1'b1;
      if (we_i && size_i == 2'h0)
        mem[a] <= wdata_i[7:0];
      else if (we_i && size_i == 2'h1)
        {mem[a], mem[a+8'h1]} <= wdata_i[15:0];
      else if (we_i)
        {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]} <= wdata_i;
      else
        rdata_o <= size_i == 2'h0 ? {24'h0, mem[a]} : size_i == 2'h1 ?
          {16'h0, mem[a], mem[a+8'h1]} :
          {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]};
    end
  end
endmodule
`default_nettype wire

// [tb/cbs_ctrl_core_tb.sv]
// Self-checking bench for cbs_ctrl_core with a memory model.
// Registers reached over classic Wishbone at 25 MHz.
`timescale 1ns/100ps
`default_nettype none
module cbs_ctrl_core_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0, we = 1'b0, wake = 1'b0, ack, mreq, mwe, mack, sleep;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, mwdata, mrdata;
  logic [1:0] msize;
  logic [23:0] maddr;
  logic [3:0] lat = 4'h0;
  int fail_count = 0, n_checks = 0;
  always #20 clk_i = ~clk_i;
  cbs_ctrl_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .mem_req_o(mreq),
    .mem_we_o(mwe), .mem_size_o(msize), .mem_addr_o(maddr),
    .mem_wdata_o(mwdata), .mem_rdata_i(mrdata), .mem_ack_i(mack),
    .wake_i(wake), .sleep_o(sleep));
  cbs_mem_model mem_m (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq),
    .we_i(mwe), .size_i(msize), .addr_i(maddr), .wdata_i(mwdata),
    .lat_i(lat), .rdata_o(mrdata), .ack_o(mack));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    req <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic run(input logic [15:0] insn);
    logic [31:0] q;
    wr(8'h00, {16'h0, insn});
    wr(8'h08, 32'h1);
    // No poll limit; the watchdog ends a hung copy
    do
      wb(1'b0, 8'h0C, 32'h0, q);
    while (q[0] !== 1'b0);
  endtask
  function automatic logic take(input logic [3:0] c, input logic [3:0] f);
    logic [7:0] b;
    b = {f[3] ^ f[1] | f[2], f[3] ^ f[1], f[3], f[1], f[2], f[0],
         f[0] | f[2], 1'b0};
    return b[c[3:1]] ^ ~c[0];
  endfunction
  task automatic t_branch;
    for (int c = 0; c < 16; c++)
      for (int f = 0; f < 16; f++)
      begin
        wr(8'h14, 32'(f));
        wr(8'h10, 32'h100);
        run({4'h1, 4'(c), 8'hF0});
        rd_chk("branch pc", 8'h10,
               take(4'(c), 4'(f)) ? 32'hF2 : 32'h102);
      end
    rd_chk("taken", 8'h0C, 32'h2);
    $display("branch test done");
  endtask
  task automatic t_ccr;
    logic [15:0] ins [7] = '{16'hA0F0, 16'hB003, 16'hC0FF, 16'h803A,
                             16'h9210, 16'h8220, 16'h0000};
    logic [7:0] ex [7] = '{8'h50, 8'h53, 8'hAC, 8'h3A, 8'h3A, 8'hC5, 8'hC5};
    mem_m.mem[8'h50] = 8'hC5;
    wr(8'h14, 32'h5C);
    wr(8'h24, 32'h40);
    wr(8'h28, 32'h50);
    wr(8'h10, 32'h1FE);
    for (int i = 0; i < 7; i++)
    begin
      run(ins[i]);
      rd_chk("flags", 8'h14, 32'(ex[i]));
    end
    chk("stored flags", 32'(mem_m.mem[8'h40]), 32'h3A);
    rd_chk("pc", 8'h10, 32'h20C);
    $display("flags test done");
  endtask
  task automatic t_copy;
    lat <= 4'h3;
    wr(8'h30, 32'h103);
    wr(8'h34, 32'h60);
    wr(8'h38, 32'h80);
    run(16'hD000);
    for (int i = 0; i < 3; i++)
      chk("copy", 32'(mem_m.mem[8'h80+i]),
          32'(8'((8'h60 + i) * 3 + 1)));
    rd_chk("count", 8'h30, 32'h100);
    rd_chk("dst", 8'h38, 32'h83);
    run(16'hD000);
    rd_chk("src", 8'h34, 32'h63);
    run(16'hD100);
    rd_chk("src", 8'h34, 32'h163);
    rd_chk("count", 8'h30, 32'h0);
    lat <= 4'h0;
    $display("copy test done");
  endtask
  task automatic t_flow;
    {mem_m.mem[8'hF0], mem_m.mem[8'hF1]} = 16'h8F00;
    {mem_m.mem[8'hF3], mem_m.mem[8'hF4], mem_m.mem[8'hF5]} = 24'h000456;
    wr(8'h3C, 32'hF0);
    wr(8'h10, 32'h20);
    run(16'h3010);
    rd_chk("call pc", 8'h10, 32'h32);
    chk("ret addr", 32'(mem_m.mem[8'hEF]), 32'h22);
    run(16'h5000);
    rd_chk("return pc", 8'h10, 32'h22);
    wr(8'h04, 32'h1234);
    run(16'h2100);
    rd_chk("jump pc", 8'h10, 32'h1234);
    run(16'h6000);
    rd_chk("exc pc", 8'h10, 32'h456);
    rd_chk("exc flags", 8'h14, 32'h8F);
    rd_chk("unmapped", 8'hFC, 32'h0);
    wr(8'h00, 32'h7000);
    wr(8'h08, 32'h1);
    for (int n = 0; n < 50 && sleep !== 1'b1; n++)
      @(posedge clk_i);
    chk("asleep", 32'(sleep), 32'h1);
    wake <= 1'b1;
    repeat (5) @(posedge clk_i);
    wake <= 1'b0;
    chk("awake", 32'(sleep), 32'h0);
    $display("flow test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem_m.mem[i] = 8'(i * 3 + 1);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_branch;
    t_ccr;
    t_copy;
    t_flow;
    close_out;
  end
  initial
  begin
    repeat (90000) @(posedge clk_i);
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
